//--- scst_reader.sv
// Purpose: Reader model sending reset, command and key frames
// Assumes: Tasks are called at falling clock edges
// Notes: Released key value line shows the inverse of the last value
// ==========================================
// Reader
module scst_reader (
    // Clock
    input wire logic mclk_i,
    // Frames toward the card
    output logic rdr_reset_o,
    output logic cmd_valid_o,
    output logic key_load_o,
    output logic [23:0] key_check_value_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle lines
    initial
    begin
        {rdr_reset_o, cmd_valid_o, key_load_o, key_check_value_o} = '0;
    end
    // One-cycle reset frame
    task automatic do_reset();
        @(negedge mclk_i);
        rdr_reset_o = 1'b1;
        @(negedge mclk_i);
        rdr_reset_o = 1'b0;
    endtask
    // Command frames held as a level
    task automatic set_cmd(input logic v);
        cmd_valid_o = v;
    endtask
    // Encrypted key with its check value
    task automatic send_key(input logic [23:0] key_check_value);
        @(negedge mclk_i);
        {key_load_o, key_check_value_o} = {1'b1, key_check_value};
        @(negedge mclk_i);
        {key_load_o, key_check_value_o} = {1'b0, ~key_check_value};
    endtask
endmodule // scst_reader

//--- scst_regs.vh
// Purpose: Constants for the smart card self-test sequencer
// Assumes: 100 MHz mclk_i
// Notes: Test indices, status words and timing counts
`ifndef SCST_REGS_VH
`define SCST_REGS_VH
// ==========================================================
// Power-up test indices (one bit per test in the test vector)
`define SCST_T_CRC_SYS 5'h00
`define SCST_T_CRC_EXT 5'h01
`define SCST_T_CRC_PKG 5'h02
`define SCST_T_KAT_TDES 5'h03
`define SCST_T_KAT_AES 5'h04
`define SCST_T_KAT_SHA1 5'h05
`define SCST_T_KAT_SHA256 5'h06
`define SCST_T_KAT_SHA512 5'h07
`define SCST_T_KAT_RSA_SIG 5'h08
`define SCST_T_KAT_RSA_WRAP 5'h09
`define SCST_T_KAT_ECDSA 5'h0A
`define SCST_T_KAT_DETERMINISTIC_RANDOM_GEN 5'h0B
`define SCST_T_CRC_KAT 5'h0C
`define SCST_T_RAM 5'h0D
`define SCST_T_SENSOR 5'h0E
`define SCST_T_AUDIT 5'h0F
`define SCST_T_LIFECYCLE 5'h10
`define SCST_T_FAULT_ATK 5'h11
`define SCST_NUM_TESTS 18
// ==========================================================
// Status word sent once before going mute (arbitrary code)
`define SCST_ERR_SW 16'h6F00
// Tests whose failure still allows the status word to be sent
`define SCST_SW_ALLOWED 18'h0F7F8
// ==========================================================
// Timing: per-test timeout in microseconds, cycle period in ns
`define SCST_CLK_NS 10
`define SCST_TEST_TMO_US 100
`define SCST_TEST_TMO_CYC ((`SCST_TEST_TMO_US * 1000) / `SCST_CLK_NS)
// Key check value width in bits (leading three cipher bytes)
`define SCST_KCV_W 24
`endif

//--- scst_seq.v
// Purpose: Power-up self-test sequencer, conditional checks and tamper watch
// Assumes: Engines run each test and report done/pass; inputs synchronous
// Notes: Commands are gated until all power-up tests pass
//
// Contract
// - After each reader reset run all go/no-go tests before answering commands.
// - Power-up checks memory CRC16 over system data, extensions, packages.
// - Power-up runs cipher, hash, RSA, ECDSA, generator KATs and critical tests.
// - Power-up also runs fault-attack guard tests.
// - Commands arriving during any self-test are ignored and unanswered.
// - Any power-up failure enters error state; no further commands processed.
// - Depending on failing test, one error status word may be sent first.
// - RSA key pair accepted only after sign/verify and encrypt/decrypt checks.
// - EC key pair accepted only after sign-then-verify check.
// - Every random output from both generators gets continuous and statistical tests.
// - Each key or PIN use first checks its error-detection code.
// - Loaded package verified by two-key triple cipher chained MAC.
// - Where enabled, package signature verified with 1024-bit RSA.
// - MAC or signature failure aborts load and erases partial package.
// - Encrypted key check value is first three bytes of zero-block encryption.
// - Monitor voltage, clock, temperature, light, single fault; card disable.
`include "scst_regs.vh"

module scst_seq #(
    parameter TMO_CYC = `SCST_TEST_TMO_CYC,
    parameter NT = `SCST_NUM_TESTS
) (
    // Clock and reset
    input wire mclk_i,
    input wire rst_b_i,
    // Reader reset pulse (contact or contactless)
    input wire rdr_reset_i,
    // Test engine handshake
    input wire test_done_i,
    input wire test_pass_i,
    // Incoming command frame
    input wire cmd_valid_i,
    // Conditional check results
    input wire rsa_gen_done_i,
    input wire rsa_sign_ok_i,
    input wire rsa_enc_ok_i,
    input wire ecc_gen_done_i,
    input wire ecc_sign_ok_i,
    input wire rng_valid_i,
    input wire rng_is_det_i,
    input wire [31:0] rng_data_i,
    input wire rng_stat_ok_i,
    input wire cred_use_i,
    input wire cred_edc_ok_i,
    input wire pkg_done_i,
    input wire pkg_mac_ok_i,
    input wire pkg_sig_en_i,
    input wire pkg_sig_ok_i,
    input wire key_load_i,
    input wire [`SCST_KCV_W-1:0] key_check_value_i,
    input wire [`SCST_KCV_W-1:0] kcv_calc_i,
    // Tamper sensors
    input wire volt_alarm_i,
    input wire freq_alarm_i,
    input wire temp_alarm_i,
    input wire light_alarm_i,
    input wire single_fault_detector_i,
    input wire card_disable_i,
    // Test engine control
    output reg test_start_o,
    output reg [4:0] test_sel_o,
    // Command gate and status
    output reg cmd_accept_o,
    output reg busy_o,
    output reg error_o,
    output reg sw_valid_o,
    output reg [15:0] sw_o,
    output reg [NT-1:0] fail_vec_o,
    // Conditional outcomes
    output reg rsa_key_ok_o,
    output reg ecc_key_ok_o,
    output reg rng_ok_o,
    output reg rng_fail_o,
    output reg cred_ok_o,
    output reg cred_fail_o,
    output reg pkg_ok_o,
    output reg pkg_erase_o,
    output reg key_load_ok_o,
    output reg key_load_fail_o,
    output reg tamper_o
);

    // ==========================================================
    // Sequencer states
    localparam ST_IDLE = 3'h0;
    localparam ST_START = 3'h1;
    localparam ST_WAIT = 3'h2;
    localparam ST_READY = 3'h3;
    localparam ST_SW = 3'h4;
    localparam ST_MUTE = 3'h5;
    // Per-test permission to send the status word before going mute
    localparam [NT-1:0] SW_MASK = `SCST_SW_ALLOWED;

    reg [2:0] state;
    reg [4:0] idx;
    reg [31:0] tmo;
    reg [31:0] rng_last_det;
    reg [31:0] rng_last_phy;
    reg rng_seen_det;
    reg rng_seen_phy;
    reg sw_ok;

    wire last_test = (idx == NT - 1);
    wire tamper_now = volt_alarm_i | freq_alarm_i | temp_alarm_i
        | light_alarm_i | single_fault_detector_i | card_disable_i;

    // ==========================================================
    // Power-up sequencer: walks every test index in turn
    always @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state <= ST_START;
            idx <= 5'h00;
            tmo <= 32'h0;
            test_start_o <= 1'b0;
            test_sel_o <= 5'h00;
            busy_o <= 1'b1;
            error_o <= 1'b0;
            sw_valid_o <= 1'b0;
            sw_o <= 16'h0000;
            fail_vec_o <= {NT{1'b0}};
            sw_ok <= 1'b0;
        end
        else if (rdr_reset_i)
        begin
            // Any reader reset restarts the whole run
            state <= ST_START;
            idx <= 5'h00;
            tmo <= 32'h0;
            test_start_o <= 1'b0;
            busy_o <= 1'b1;
            error_o <= 1'b0;
            sw_valid_o <= 1'b0;
            fail_vec_o <= {NT{1'b0}};
        end
        else
        begin
            test_start_o <= 1'b0;
            sw_valid_o <= 1'b0;
            case (state)
                ST_START:
                begin
                    // CRC, KAT, critical and fault-attack tests by index
                    test_start_o <= 1'b1;
                    test_sel_o <= idx;
                    tmo <= 32'h0;
                    state <= ST_WAIT;
                end
                ST_WAIT:
                begin
                    tmo <= tmo + 32'h1;
                    if ((test_done_i && !test_pass_i) || tamper_now
                        || tmo >= TMO_CYC - 1)
                    begin
                        fail_vec_o[idx] <= 1'b1;
                        sw_ok <= SW_MASK[idx];
                        state <= ST_SW;
                    end
                    else if (test_done_i)
                    begin
                        if (last_test)
                        begin
                            busy_o <= 1'b0;
                            state <= ST_READY;
                        end
                        else
                        begin
                            idx <= idx + 5'h01;
                            state <= ST_START;
                        end
                    end
                end
                ST_READY:
                begin
                    if (tamper_now)
                    begin
                        busy_o <= 1'b1;
                        sw_ok <= 1'b1;
                        state <= ST_SW;
                    end
                end
                ST_SW:
                begin
                    // One status word for some failures, then mute
                    error_o <= 1'b1;
                    busy_o <= 1'b1;
                    sw_valid_o <= sw_ok;
                    sw_o <= `SCST_ERR_SW;
                    state <= ST_MUTE;
                end
                ST_MUTE:
                    state <= ST_MUTE;
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Command gate: open only once every test has passed
    always @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            cmd_accept_o <= 1'b0;
        else
            cmd_accept_o <= cmd_valid_i && state == ST_READY && !tamper_now
                && !rdr_reset_i;
    end

    // ==========================================================
    // Conditional checks: key generation, RNG, credentials, loads
    always @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rsa_key_ok_o <= 1'b0;
            ecc_key_ok_o <= 1'b0;
            rng_ok_o <= 1'b0;
            rng_fail_o <= 1'b0;
            cred_ok_o <= 1'b0;
            cred_fail_o <= 1'b0;
            pkg_ok_o <= 1'b0;
            pkg_erase_o <= 1'b0;
            key_load_ok_o <= 1'b0;
            key_load_fail_o <= 1'b0;
            tamper_o <= 1'b0;
            rng_last_det <= 32'h0;
            rng_last_phy <= 32'h0;
            rng_seen_det <= 1'b0;
            rng_seen_phy <= 1'b0;
        end
        else
        begin
            // Both pair checks must pass before the RSA pair is taken
            rsa_key_ok_o <= rsa_gen_done_i && rsa_sign_ok_i && rsa_enc_ok_i;
            ecc_key_ok_o <= ecc_gen_done_i && ecc_sign_ok_i;
            // Continuous test: repeat of previous word fails, per source
            rng_ok_o <= 1'b0;
            rng_fail_o <= 1'b0;
            if (rng_valid_i)
            begin
                if (rng_is_det_i)
                begin
                    rng_last_det <= rng_data_i;
                    rng_seen_det <= 1'b1;
                    rng_fail_o <= (rng_seen_det && rng_data_i == rng_last_det)
                        || !rng_stat_ok_i;
                    rng_ok_o <= !(rng_seen_det && rng_data_i == rng_last_det)
                        && rng_stat_ok_i;
                end
                else
                begin
                    rng_last_phy <= rng_data_i;
                    rng_seen_phy <= 1'b1;
                    rng_fail_o <= (rng_seen_phy && rng_data_i == rng_last_phy)
                        || !rng_stat_ok_i;
                    rng_ok_o <= !(rng_seen_phy && rng_data_i == rng_last_phy)
                        && rng_stat_ok_i;
                end
            end
            // Credential integrity before each use
            cred_ok_o <= cred_use_i && cred_edc_ok_i;
            cred_fail_o <= cred_use_i && !cred_edc_ok_i;
            // Package load: MAC always, signature when enabled
            pkg_ok_o <= pkg_done_i && pkg_mac_ok_i
                && (!pkg_sig_en_i || pkg_sig_ok_i);
            pkg_erase_o <= pkg_done_i && (!pkg_mac_ok_i
                || (pkg_sig_en_i && !pkg_sig_ok_i));
            // Key check value compare after decryption
            key_load_ok_o <= key_load_i && key_check_value_i == kcv_calc_i;
            key_load_fail_o <= key_load_i && key_check_value_i != kcv_calc_i;
            tamper_o <= tamper_now;
        end
    end

endmodule // scst_seq

//--- scst_seq_sva.sv
// Purpose: Port-level checks of the self-test sequencer
// Assumes: Sees only the top module ports
// Notes: Bound into scst_seq below the module
`include "scst_regs.vh"
// ==========================================
// Checker
module scst_seq_sva #(
    parameter TMO_CYC = 20,
    parameter NT = 18
) (
    // Clock and reset
    input wire mclk_i,
    input wire rst_b_i,
    // Watched inputs
    input wire rdr_reset_i,
    input wire cmd_valid_i,
    input wire key_load_i,
    input wire [`SCST_KCV_W-1:0] key_check_value_i,
    input wire [`SCST_KCV_W-1:0] kcv_calc_i,
    input wire volt_alarm_i,
    // Watched outputs
    input wire test_start_o,
    input wire [4:0] test_sel_o,
    input wire cmd_accept_o,
    input wire busy_o,
    input wire error_o,
    input wire sw_valid_o,
    input wire [15:0] sw_o,
    input wire [NT-1:0] fail_vec_o,
    input wire key_load_ok_o,
    input wire tamper_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    // Command gate, error state and status word
    a_cmd_when_ready: assert property (cmd_accept_o |-> $past(cmd_valid_i) && !$past(busy_o))
        else $error("command taken while busy");
    a_mute_in_error: assert property (error_o |-> !cmd_accept_o)
        else $error("command taken in error");
    a_error_holds: assert property (error_o && !rdr_reset_i |=> error_o)
        else $error("error left without reset");
    a_status_word: assert property (sw_valid_o |-> error_o && sw_o == `SCST_ERR_SW)
        else $error("bad status word");
    a_status_once: assert property (sw_valid_o |=> !sw_valid_o [*4])
        else $error("status word repeated");
    a_fail_to_error: assert property ($rose(|fail_vec_o) ##1 !rdr_reset_i |-> error_o)
        else $error("failure without error");
    // Test order and completion
    a_last_test_done: assert property ($fell(busy_o) |-> test_sel_o == NT - 1 && !error_o)
        else $error("ready before last test");
    a_tests_in_order: assert property (test_start_o && test_sel_o != 0
        |-> test_sel_o == $past(test_sel_o) + 5'h01)
        else $error("test skipped");
    // Tamper and key load
    a_tamper_seen: assert property (volt_alarm_i |=> tamper_o)
        else $error("tamper not flagged");
    a_key_check: assert property (key_load_i
        |=> key_load_ok_o == ($past(key_check_value_i) == $past(kcv_calc_i)))
        else $error("key check wrong");
    c_cmd: cover property (cmd_accept_o);
    c_sw: cover property (sw_valid_o);
    c_ready: cover property ($fell(busy_o));
endmodule // scst_seq_sva
bind scst_seq scst_seq_sva #(.TMO_CYC(TMO_CYC), .NT(NT)) u_sva (.*);

//--- scst_seq_tb.sv
// Purpose: Self-checking bench for the self-test sequencer
// Assumes: Test engine modelled here, reader in scst_reader
// Notes: Test timeout shortened to 20 cycles
`include "scst_regs.vh"
// ==========================================
// Bench
module scst_seq_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk_i = 0, rst_b_i = 0, test_done_i = 0, test_pass_i = 0;
    logic rdr_reset_i, cmd_valid_i, key_load_i;
    logic [23:0] key_check_value_i;
    logic [23:0] kcv_calc_i = 24'hA1B2C3;
    logic rsa_gen_done_i = 0, rsa_sign_ok_i = 0, rsa_enc_ok_i = 0, ecc_gen_done_i = 0;
    logic ecc_sign_ok_i = 0, rng_valid_i = 0, rng_is_det_i = 0, rng_stat_ok_i = 1;
    logic [31:0] rng_data_i = 0;
    logic cred_use_i = 0, cred_edc_ok_i = 0, pkg_done_i = 0, pkg_mac_ok_i = 0;
    logic pkg_sig_en_i = 0, pkg_sig_ok_i = 0, card_disable_i;
    logic volt_alarm_i, freq_alarm_i, temp_alarm_i, light_alarm_i, single_fault_detector_i;
    logic [5:0] alarm = 0;
    logic test_start_o, cmd_accept_o, busy_o, error_o, sw_valid_o, rsa_key_ok_o, ecc_key_ok_o;
    logic rng_ok_o, rng_fail_o, cred_ok_o, cred_fail_o, pkg_ok_o, pkg_erase_o, tamper_o;
    logic key_load_ok_o, key_load_fail_o;
    logic [4:0] test_sel_o;
    logic [15:0] sw_o;
    logic [17:0] fail_vec_o;
    int miscompares = 0, checked = 0, fi = 99, cnt = 0, exp_sel = 0, cyc = 0;
    bit hang = 0;
    assign {volt_alarm_i, freq_alarm_i, temp_alarm_i, light_alarm_i, single_fault_detector_i,
        card_disable_i} = alarm;
    scst_seq #(.TMO_CYC(20)) u_dut (.*);
    scst_reader u_rdr (.mclk_i(mclk_i), .rdr_reset_o(rdr_reset_i), .cmd_valid_o(cmd_valid_i),
        .key_load_o(key_load_i), .key_check_value_o(key_check_value_i));
    always #5 mclk_i = ~mclk_i;
    // Cycle ceiling against hangs
    always @(posedge mclk_i)
    begin
        cyc++;
        if (cyc == 8000)
        begin
            miscompares++;
            tally_and_finish();
        end
    end
    // Test engine: answers 3 cycles after start, fails or hangs on index fi
    always @(negedge mclk_i)
    begin
        test_done_i <= 0;
        if (test_start_o === 1'b1)
        begin
            chk(test_sel_o, exp_sel);
            exp_sel++;
            cnt = 3;
        end
        else if (cnt > 0 && !(hang && test_sel_o == fi))
        begin
            cnt--;
            test_done_i <= (cnt == 0);
            test_pass_i <= (test_sel_o != fi);
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic step();
        @(negedge mclk_i);
    endtask
    task automatic tally_and_finish();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Reader reset, all tests pass; commands silent until ready
    task automatic t_power();
        int n = 0;
        {fi, hang} = {32'd99, 1'b0};
        u_rdr.do_reset();
        exp_sel = 0;
        u_rdr.set_cmd(1);
        while (busy_o !== 1'b0 && n < 400)
        begin
            chk(cmd_accept_o, 0);
            step();
            n++;
        end
        step();
        chk({cmd_accept_o, fail_vec_o}, {1'b1, 18'h0});
        chk(exp_sel, 18);
        u_rdr.set_cmd(0);
        $display("t_power done");
    endtask
    // One test fails or hangs: status word per mask, then mute
    task automatic t_fail(input int f, input bit h);
        int n = 0;
        logic sw_seen = 0;
        {fi, hang} = {f, h};
        u_rdr.do_reset();
        exp_sel = 0;
        while (error_o !== 1'b1 && n < 400)
        begin
            step();
            sw_seen |= (sw_valid_o === 1'b1);
            n++;
        end
        chk(sw_seen, (`SCST_SW_ALLOWED >> f) & 1);
        chk(fail_vec_o, 1 << f);
        chk(sw_o, `SCST_ERR_SW);
        u_rdr.set_cmd(1);
        repeat (4)
        begin
            step();
            chk({cmd_accept_o, error_o}, 2'b01);
        end
        u_rdr.set_cmd(0);
        $display("t_fail done");
    endtask
    // Conditional checks on keys, random words, credentials, packages
    task automatic t_cond();
        {rsa_gen_done_i, rsa_sign_ok_i, rsa_enc_ok_i} = 3'b111;
        step();
        chk(rsa_key_ok_o, 1);
        rsa_enc_ok_i = 0;
        step();
        chk(rsa_key_ok_o, 0);
        {rsa_gen_done_i, ecc_gen_done_i, ecc_sign_ok_i} = 3'b010;
        step();
        chk(ecc_key_ok_o, 0);
        ecc_sign_ok_i = 1;
        step();
        chk(ecc_key_ok_o, 1);
        {ecc_gen_done_i, rng_valid_i, rng_is_det_i, rng_data_i} = {3'b011, 32'h5A5A0001};
        step();
        chk({rng_ok_o, rng_fail_o}, 2'b10);
        step();
        chk({rng_ok_o, rng_fail_o}, 2'b01);
        rng_is_det_i = 0;
        step();
        chk({rng_ok_o, rng_fail_o}, 2'b10);
        {rng_data_i, rng_stat_ok_i} = {32'h5A5A0002, 1'b0};
        step();
        chk({rng_ok_o, rng_fail_o}, 2'b01);
        {rng_valid_i, cred_use_i, cred_edc_ok_i} = 3'b010;
        step();
        chk({cred_ok_o, cred_fail_o}, 2'b01);
        cred_edc_ok_i = 1;
        step();
        chk({cred_ok_o, cred_fail_o}, 2'b10);
        {cred_use_i, pkg_done_i, pkg_mac_ok_i, pkg_sig_en_i} = 4'b0111;
        step();
        chk({pkg_ok_o, pkg_erase_o}, 2'b01);
        pkg_sig_ok_i = 1;
        step();
        chk({pkg_ok_o, pkg_erase_o}, 2'b10);
        {pkg_mac_ok_i, pkg_sig_en_i} = 2'b00;
        step();
        chk({pkg_ok_o, pkg_erase_o}, 2'b01);
        pkg_done_i = 0;
        u_rdr.send_key(24'hA1B2C3);
        chk({key_load_ok_o, key_load_fail_o}, 2'b10);
        u_rdr.send_key(24'hA1B2C2);
        chk({key_load_ok_o, key_load_fail_o}, 2'b01);
        kcv_calc_i = 24'h5E4D3C;
        u_rdr.send_key(24'h5E4D3C);
        chk({key_load_ok_o, key_load_fail_o}, 2'b10);
        $display("t_cond done");
    endtask
    // Each sensor in ready state: flagged, then error until reset
    task automatic t_tamper();
        for (int i = 0; i < 6; i++)
        begin
            alarm = 6'h01 << i;
            step();
            chk(tamper_o, 1);
            step();
            chk({error_o, busy_o}, 2'b11);
            alarm = 0;
            t_power();
        end
        $display("t_tamper done");
    endtask
    // Main sequence
    initial
    begin
        repeat (16) step();
        rst_b_i = 1;
        t_power();
        t_fail(3, 0);
        t_fail(0, 0);
        t_fail(5, 1);
        t_power();
        t_cond();
        t_tamper();
        tally_and_finish();
    end
endmodule // scst_seq_tb
